// *** src/gptpc_params.svh ***
`ifndef GPTPC_PARAMS_SVH
`define GPTPC_PARAMS_SVH
// register bus address width
`define GPTPC_AW          8
// register byte offsets
`define GPTPC_OFF_CNT_LO  8'h10
`define GPTPC_OFF_CNT_HI  8'h14
`define GPTPC_OFF_PRD_LO  8'h18
`define GPTPC_OFF_PRD_HI  8'h1c
`define GPTPC_OFF_CTL     8'h20
`define GPTPC_OFF_GCTL    8'h24
// reset value of every register
`define GPTPC_RST_WORD    32'h0000_0000
// writable bits of the control words
`define GPTPC_CTL_WMASK   32'h00c0_01fe
`define GPTPC_GCTL_WMASK  32'h0000_0f0f
// timer_control field positions
`define GPTPC_ENA_HI      22
`define GPTPC_CLK_SEL     8
`define GPTPC_ENA_LO      6
`define GPTPC_PW_SEL      4
`define GPTPC_CLK_MODE    3
`define GPTPC_IN_INV      2
`define GPTPC_OUT_INV     1
`define GPTPC_STATUS      0
// timer_global_control field positions
`define GPTPC_DDR         12
`define GPTPC_PSC         8
`define GPTPC_MODE        2
`define GPTPC_HI_RUN      1
`define GPTPC_LO_RUN      0
// enable select codes
`define GPTPC_ENA_ONCE    2'h1
`define GPTPC_ENA_CONT    2'h2
// timer mode codes
`define GPTPC_MODE_64     2'h0
`define GPTPC_MODE_UNCH   2'h1
`define GPTPC_MODE_CHAIN  2'h3
// bus responses
`define GPTPC_RESP_OKAY   2'h0
`define GPTPC_RESP_SLVERR 2'h2
`endif

// *** src/gptpc_pkg.sv ***
`include "gptpc_params.svh"
package gptpc_pkg;
    // master to slave signals of the register bus
    typedef struct packed {
        logic                   awvalid;
        logic [`GPTPC_AW-1:0]   awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`GPTPC_AW-1:0]   araddr;
        logic                   rready;
    } gptpc_axil_req_t;
    // slave to master signals of the register bus
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } gptpc_axil_rsp_t;
    // committed register write
    typedef struct packed {
        logic                   en;
        logic [`GPTPC_AW-1:0]   addr;
        logic [31:0]            data;
        logic [3:0]             strb;
    } gptpc_wr_t;
endpackage : gptpc_pkg

// *** src/gptpc_axil_slave.sv ***
`timescale 1ns/1ps
`include "gptpc_params.svh"
module gptpc_axil_slave (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire gptpc_pkg::gptpc_axil_req_t axil_req,
    output gptpc_pkg::gptpc_axil_rsp_t      axil_rsp,
    output gptpc_pkg::gptpc_wr_t            wr,
    input  wire logic                      wr_ok,
    output logic [`GPTPC_AW-1:0]           rd_addr,
    input  wire logic [31:0]               rd_data,
    input  wire logic                      rd_ok
);
    logic                 aw_full_q, aw_full_d;   // write address held
    logic                 w_full_q,  w_full_d;    // write data held
    logic [`GPTPC_AW-1:0] addr_q,    addr_d;
    logic [31:0]          data_q,    data_d;
    logic [3:0]           strb_q,    strb_d;
    logic                 bvalid_q,  bvalid_d;
    logic [1:0]           bresp_q,   bresp_d;
    logic                 rvalid_q,  rvalid_d;
    logic [31:0]          rdata_q,   rdata_d;
    logic [1:0]           rresp_q,   rresp_d;
    logic                 commit;                 // both halves held, response free

    assign commit = aw_full_q & w_full_q & ~bvalid_q;

    // next state of both channels
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        addr_d    = addr_q;
        data_d    = data_q;
        strb_d    = strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (axil_req.awvalid && !aw_full_q) begin
            aw_full_d = 1'b1;
            addr_d    = axil_req.awaddr;
        end
        if (axil_req.wvalid && !w_full_q) begin
            w_full_d = 1'b1;
            data_d   = axil_req.wdata;
            strb_d   = axil_req.wstrb;
        end
        // write lands and response rises on the same edge
        if (commit) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_ok ? `GPTPC_RESP_OKAY : `GPTPC_RESP_SLVERR;
        end
        if (bvalid_q && axil_req.bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && axil_req.rready) begin
            rvalid_d = 1'b0;
        end
        // read data captured at the address handshake
        if (axil_req.arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_ok ? rd_data : 32'h0000_0000;
            rresp_d  = rd_ok ? `GPTPC_RESP_OKAY : `GPTPC_RESP_SLVERR;
        end
    end

    // channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            addr_q    <= '0;
            data_q    <= 32'h0000_0000;
            strb_q    <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            addr_q    <= addr_d;
            data_q    <= data_d;
            strb_q    <= strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // outputs
    assign axil_rsp.awready = ~aw_full_q;
    assign axil_rsp.wready  = ~w_full_q;
    assign axil_rsp.bvalid  = bvalid_q;
    assign axil_rsp.bresp   = bresp_q;
    assign axil_rsp.arready = ~rvalid_q;
    assign axil_rsp.rvalid  = rvalid_q;
    assign axil_rsp.rdata   = rdata_q;
    assign axil_rsp.rresp   = rresp_q;
    assign wr.en            = commit;
    assign wr.addr          = addr_q;
    assign wr.data          = data_q;
    assign wr.strb          = strb_q;
    assign rd_addr          = axil_req.araddr;
endmodule : gptpc_axil_slave

// *** src/gptpc_top.sv ***
`timescale 1ns/1ps
`include "gptpc_params.svh"
module gptpc_top (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire gptpc_pkg::gptpc_axil_req_t axil_req,
    output gptpc_pkg::gptpc_axil_rsp_t      axil_rsp,
    input  wire logic                      timer_pin_i,
    output logic                           timer_pin_o,
    output logic                           timer_pin_oe,
    output logic                           match_interrupt_low,
    output logic                           match_interrupt_high,
    output logic                           match_dma_event_low,
    output logic                           match_dma_event_high
);
    gptpc_pkg::gptpc_wr_t wr;                       // committed write
    logic [`GPTPC_AW-1:0] rd_addr;                  // read address
    logic [31:0]          rd_data;                  // read mux
    logic                 rd_ok, wr_ok;             // address decodes
    logic [31:0]          strb_mask;                // byte lanes as bit mask
    logic [31:0]          prd_lo_q, prd_lo_d;       // period_lower_half
    logic [31:0]          prd_hi_q, prd_hi_d;       // period_upper_half
    logic [31:0]          ctl_q, ctl_d;             // timer_control, writable bits
    logic [31:0]          gctl_q, gctl_d;           // timer_global_control, writable bits
    logic [31:0]          cnt_lo_q, cnt_lo_d;       // counter_lower_half
    logic [31:0]          cnt_hi_q, cnt_hi_d;       // counter_upper_half
    logic [3:0]           ddr_q, ddr_d;             // upper_divide_down_count
    logic                 step_q, step_d;           // prescaler wrap, one cycle late
    logic                 chain_q, chain_d;         // upper match feeding lower in chain
    logic                 pin_prev_q;               // last conditioned pin level
    logic                 out_q, out_d;             // output_level_status
    logic [1:0]           pw_q, pw_d;               // pulse cycles still to go
    logic                 evt_lo_q, evt_hi_q;       // registered match pulses
    logic                 match_lo, match_hi;       // match on this edge
    logic [64:0]          s64, slo, shi;            // step results {hit, value}

    // control fields
    logic [1:0] ena_lo, ena_hi, pw_sel, mode;
    logic [3:0] psc;
    logic       clk_sel, clk_mode, in_inv, out_inv, run_lo, run_hi;
    logic       m64, mun, mch, ext_lvl, tick_lo, go_lo, go_hi, lo_tick, hi_en;

    assign ena_lo   = ctl_q[`GPTPC_ENA_LO +: 2];
    assign ena_hi   = ctl_q[`GPTPC_ENA_HI +: 2];
    assign pw_sel   = ctl_q[`GPTPC_PW_SEL +: 2];
    assign clk_sel  = ctl_q[`GPTPC_CLK_SEL];
    assign clk_mode = ctl_q[`GPTPC_CLK_MODE];
    assign in_inv   = ctl_q[`GPTPC_IN_INV];
    assign out_inv  = ctl_q[`GPTPC_OUT_INV];
    assign psc      = gctl_q[`GPTPC_PSC +: 4];
    assign mode     = gctl_q[`GPTPC_MODE +: 2];
    assign run_hi   = gctl_q[`GPTPC_HI_RUN];
    assign run_lo   = gctl_q[`GPTPC_LO_RUN];
    // mode decode, code 2 runs the lower half alone and stops the upper half
    assign m64      = (mode == `GPTPC_MODE_64);
    assign mun      = (mode == `GPTPC_MODE_UNCH);
    assign mch      = (mode == `GPTPC_MODE_CHAIN);
    // enable decode, code 3 counts nothing
    assign go_lo    = (ena_lo == `GPTPC_ENA_ONCE) || (ena_lo == `GPTPC_ENA_CONT);
    assign go_hi    = (ena_hi == `GPTPC_ENA_ONCE) || (ena_hi == `GPTPC_ENA_CONT);

    // conditioned pin and count clock enable
    assign ext_lvl  = timer_pin_i ^ in_inv;
    assign tick_lo  = clk_sel ? (ext_lvl & ~pin_prev_q) : 1'b1;
    assign lo_tick  = mch ? chain_q : tick_lo;
    // upper half: own enable when unchained, prescales lower when chained
    assign hi_en    = run_hi & (mun ? go_hi : (mch & go_lo));

    // one count step: hold or clear at period, else increment
    function automatic logic [64:0] step(input logic [63:0] c, input logic [63:0] p,
                                         input logic cont);
        logic [63:0] n;
        n = c + 64'h1;
        if (c == p) begin
            step = {1'b0, (cont ? 64'h0 : c)};
        end else begin
            step = {(n == p), n};
        end
    endfunction : step

    assign s64 = step({cnt_hi_q, cnt_lo_q}, {prd_hi_q, prd_lo_q},
                      ena_lo == `GPTPC_ENA_CONT);
    assign slo = step({32'h0, cnt_lo_q}, {32'h0, prd_lo_q},
                      ena_lo == `GPTPC_ENA_CONT);
    assign shi = step({32'h0, cnt_hi_q}, {32'h0, prd_hi_q},
                      mch || (ena_hi == `GPTPC_ENA_CONT));

    // counter next state
    always_comb begin
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        ddr_d    = ddr_q;
        step_d   = 1'b0;
        chain_d  = 1'b0;
        match_lo = 1'b0;
        match_hi = 1'b0;
        if (m64) begin
            // both run bits needed for one long counter
            if (run_lo && run_hi && go_lo && tick_lo) begin
                {cnt_hi_d, cnt_lo_d} = s64[63:0];
                match_lo = s64[64];
            end
        end else begin
            // lower half on its own clock or the chain pulse
            if (run_lo && go_lo && lo_tick) begin
                cnt_lo_d = slo[31:0];
                match_lo = slo[64];
            end
            // prescaler runs on every upper timer clock
            if (hi_en && (mun || tick_lo)) begin
                if (ddr_q == psc) begin
                    ddr_d  = 4'h0;
                    step_d = 1'b1;
                end else begin
                    ddr_d = ddr_q + 4'h1;
                end
            end
            // upper counter moves the cycle after the wrap
            if (hi_en && step_q) begin
                cnt_hi_d = shi[31:0];
                match_hi = shi[64] & mun;
                chain_d  = shi[64] & mch;
            end
        end
    end

    // output level next state
    always_comb begin
        out_d = out_q;
        pw_d  = pw_q;
        if (!run_lo) begin
            out_d = 1'b0;
            pw_d  = 2'h0;
        end else if (clk_mode) begin
            if (match_lo) begin
                out_d = ~out_q;
            end
        end else if (match_lo) begin
            out_d = 1'b1;
            pw_d  = pw_sel;
        end else if (out_q) begin
            if (pw_q == 2'h0) begin
                out_d = 1'b0;
            end else begin
                pw_d = pw_q - 2'h1;
            end
        end
    end

    // byte lanes expanded to bits
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign strb_mask[8*b +: 8] = {8{wr.strb[b]}};
    end

    // register write next state, reserved bits never stored
    always_comb begin
        prd_lo_d = prd_lo_q;
        prd_hi_d = prd_hi_q;
        ctl_d    = ctl_q;
        gctl_d   = gctl_q;
        if (wr.en) begin
            unique case (wr.addr)
                `GPTPC_OFF_PRD_LO: prd_lo_d = (prd_lo_q & ~strb_mask)
                                              | (wr.data & strb_mask);
                `GPTPC_OFF_PRD_HI: prd_hi_d = (prd_hi_q & ~strb_mask)
                                              | (wr.data & strb_mask);
                `GPTPC_OFF_CTL:    ctl_d = (ctl_q & ~(strb_mask & `GPTPC_CTL_WMASK))
                                           | (wr.data & strb_mask & `GPTPC_CTL_WMASK);
                `GPTPC_OFF_GCTL:   gctl_d = (gctl_q & ~(strb_mask & `GPTPC_GCTL_WMASK))
                                            | (wr.data & strb_mask & `GPTPC_GCTL_WMASK);
                default:           ;                                // counters read only
            endcase
        end
    end

    // write decode, counters accept and ignore
    assign wr_ok = (wr.addr == `GPTPC_OFF_CNT_LO) || (wr.addr == `GPTPC_OFF_CNT_HI) ||
                   (wr.addr == `GPTPC_OFF_PRD_LO) || (wr.addr == `GPTPC_OFF_PRD_HI) ||
                   (wr.addr == `GPTPC_OFF_CTL)    || (wr.addr == `GPTPC_OFF_GCTL);

    // read mux
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            `GPTPC_OFF_CNT_LO: rd_data = cnt_lo_q;
            `GPTPC_OFF_CNT_HI: rd_data = cnt_hi_q;
            `GPTPC_OFF_PRD_LO: rd_data = prd_lo_q;
            `GPTPC_OFF_PRD_HI: rd_data = prd_hi_q;
            `GPTPC_OFF_CTL:    rd_data = ctl_q | {31'h0, out_q};
            `GPTPC_OFF_GCTL:   rd_data = {16'h0, ddr_q, gctl_q[11:0]};
            default:           rd_ok   = 1'b0;
        endcase
    end

    // all state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prd_lo_q   <= `GPTPC_RST_WORD;
            prd_hi_q   <= `GPTPC_RST_WORD;
            ctl_q      <= `GPTPC_RST_WORD;
            gctl_q     <= `GPTPC_RST_WORD;
            cnt_lo_q   <= `GPTPC_RST_WORD;
            cnt_hi_q   <= `GPTPC_RST_WORD;
            ddr_q      <= 4'h0;
            step_q     <= 1'b0;
            chain_q    <= 1'b0;
            pin_prev_q <= 1'b0;
            out_q      <= 1'b0;
            pw_q       <= 2'h0;
            evt_lo_q   <= 1'b0;
            evt_hi_q   <= 1'b0;
        end else begin
            prd_lo_q   <= prd_lo_d;
            prd_hi_q   <= prd_hi_d;
            ctl_q      <= ctl_d;
            gctl_q     <= gctl_d;
            cnt_lo_q   <= cnt_lo_d;
            cnt_hi_q   <= cnt_hi_d;
            ddr_q      <= ddr_d;
            step_q     <= step_d;
            chain_q    <= chain_d;
            pin_prev_q <= ext_lvl;
            out_q      <= out_d;
            pw_q       <= pw_d;
            evt_lo_q   <= match_lo;
            evt_hi_q   <= match_hi;
        end
    end

    // pins and event outputs
    assign timer_pin_o          = out_q ^ out_inv;
    assign timer_pin_oe         = ~clk_sel;
    assign match_interrupt_low  = evt_lo_q;
    assign match_dma_event_low  = evt_lo_q;
    assign match_interrupt_high = evt_hi_q;
    assign match_dma_event_high = evt_hi_q;

    // register bus slave
    gptpc_axil_slave u_bus (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .axil_req (axil_req),
        .axil_rsp (axil_rsp),
        .wr       (wr),
        .wr_ok    (wr_ok),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data),
        .rd_ok    (rd_ok)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // pulse start and quiet cycles of a two-cycle pulse
    sequence pulse_start;
        run_lo && !clk_mode && match_lo;
    endsequence
    sequence pulse_quiet;
        run_lo && !clk_mode && !match_lo && pw_sel == 2'h1;
    endsequence

    period_write_a: assert property (wr.en && wr.addr == `GPTPC_OFF_PRD_LO && wr.strb == 4'hf
        |=> prd_lo_q == $past(wr.data)) else $error("period write lost");
    once_stop_a: assert property (mun && run_lo && ena_lo == `GPTPC_ENA_ONCE &&
        cnt_lo_q == prd_lo_q |=> cnt_lo_q == $past(cnt_lo_q)) else $error("one-shot ran on");
    cont_clear_a: assert property (mun && run_lo && ena_lo == `GPTPC_ENA_CONT && tick_lo &&
        cnt_lo_q == prd_lo_q |=> cnt_lo_q == 32'h0) else $error("no clear after match");
    lo_hold_a: assert property (!run_lo |=> cnt_lo_q == $past(cnt_lo_q))
        else $error("lower count moved in reset");
    hi_hold_a: assert property (!run_hi |=> cnt_hi_q == $past(cnt_hi_q))
        else $error("upper count moved in reset");
    status_clear_a: assert property (!run_lo |=> !out_q)
        else $error("status not cleared");
    pulse_on_a: assert property (pulse_start |=> out_q)
        else $error("pulse did not start");
    pulse_len_a: assert property ((pulse_start and pw_sel == 2'h1) ##1 pulse_quiet ##1
        pulse_quiet |=> !out_q) else $error("pulse width wrong");
    clock_toggle_a: assert property (run_lo && clk_mode && match_lo |=> out_q != $past(out_q))
        else $error("clock mode did not toggle");
    status_read_a: assert property (axil_req.arvalid && axil_rsp.arready &&
        axil_req.araddr == `GPTPC_OFF_CTL |=> axil_rsp.rdata[0] == $past(out_q) &&
        axil_rsp.rdata[31:24] == 8'h0) else $error("status read wrong");
    prescale_wrap_a: assert property (mun && hi_en && ddr_q == psc |=> ddr_q == 4'h0 && step_q)
        else $error("prescaler did not wrap");
    hi_step_a: assert property (mun && hi_en && step_q && cnt_hi_q != prd_hi_q
        |=> cnt_hi_q == $past(cnt_hi_q) + 32'h1) else $error("upper count missed step");
    evt_lo_match_a: assert property (evt_lo_q && mun && $past(mun) |->
        cnt_lo_q == $past(prd_lo_q)) else $error("low event without match");
endmodule : gptpc_top

// *** tb/gptpc_event_sink.sv ***
`timescale 1ns/1ps
// cpu interrupt and dma event inputs: counts match pulses
module gptpc_event_sink (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic irq_lo,
    input  wire logic irq_hi,
    input  wire logic dma_lo,
    input  wire logic dma_hi,
    output int        cnt_lo,
    output int        cnt_hi,
    output int        bad
);
    // count pulses; interrupt and dma event must agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_lo <= 0;
            cnt_hi <= 0;
            bad    <= 0;
        end else begin
            if (irq_lo === 1'b1) cnt_lo <= cnt_lo + 1;
            if (irq_hi === 1'b1) cnt_hi <= cnt_hi + 1;
            if (irq_lo !== dma_lo || irq_hi !== dma_hi) bad <= bad + 1;
        end
    end
endmodule : gptpc_event_sink

// *** tb/gp_timer_period_control_tb.sv ***
`timescale 1ns/1ps
module gp_timer_period_control_tb;
    logic                       aclk;
    logic                       aresetn;
    gptpc_pkg::gptpc_axil_req_t req;
    gptpc_pkg::gptpc_axil_rsp_t rsp;
    logic                       pin_i, pin_o, pin_oe, il, ih, dl, dh;
    int                         fails, checks, cl, ch, bad, k;
    logic [31:0]                rv;
    gptpc_top gptpc_top_inst (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
        .axil_rsp(rsp), .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe(pin_oe),
        .match_interrupt_low(il), .match_interrupt_high(ih),
        .match_dma_event_low(dl), .match_dma_event_high(dh));
    gptpc_event_sink gptpc_event_sink_inst (.aclk(aclk), .aresetn(aresetn), .irq_lo(il),
        .irq_hi(ih), .dma_lo(dl), .dma_hi(dh), .cnt_lo(cl), .cnt_hi(ch), .bad(bad));
    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // bus write, response code compared
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        if (n == 50) begin fails++; final_report(); end
        req.bready <= 1'b0;
        chk(32'(rsp.bresp), 32'(e));
        @(posedge aclk);
    endtask : wr
    // bus read into rv
    task automatic rd(input logic [7:0] a);
        int n;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        if (n == 50) begin fails++; final_report(); end
        rv = rsp.rdata;
        req.rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // t falling edges on the timer pin, two cycles per level
    task automatic pin_ticks(input int t);
        repeat (t) begin
            pin_i <= 1'b1;
            repeat (2) @(posedge aclk);
            pin_i <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask : pin_ticks
    // main sequence
    initial begin
        req = '0;
        req.wstrb = 4'hf;
        pin_i = 1'b0;
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h20); chk(rv, 32'h0);
        rd(8'h24); chk(rv, 32'h0);
        wr(8'h18, 32'h0000_0005, 2'h0); rd(8'h18); chk(rv, 32'h5);
        wr(8'h20, 32'hffff_ffff, 2'h0); rd(8'h20); chk(rv, 32'h00c0_01fe);
        wr(8'h40, 32'h1, 2'h2);
        wr(8'h20, 32'h0, 2'h0);
        // unchained, both halves run, prescale 1
        wr(8'h1c, 32'h0000_0002, 2'h0);
        wr(8'h24, 32'h0000_0107, 2'h0);
        // lower one-shot: stops at period, one event
        wr(8'h20, 32'h0000_0040, 2'h0);
        repeat (30) @(posedge aclk);
        rd(8'h10); chk(rv, 32'h5);
        chk(32'(cl), 32'h1);
        // upper one-shot through prescaler
        wr(8'h20, 32'h0040_0040, 2'h0);
        repeat (30) @(posedge aclk);
        rd(8'h14); chk(rv, 32'h2);
        chk(32'(ch), 32'h1);
        // output inversion on pin, internal clock drives pin
        wr(8'h20, 32'h0000_0002, 2'h0);
        chk(32'(pin_o), 32'h1);
        chk(32'(pin_oe), 32'h1);
        wr(8'h24, 32'h0000_0104, 2'h0); rd(8'h20); chk(rv, 32'h2);
        chk(32'(bad), 32'h0);
        // clock mode one-shot: one toggle, then run bit low clears status
        wr(8'h18, 32'h0000_0008, 2'h0);
        wr(8'h20, 32'h0000_004a, 2'h0);
        wr(8'h24, 32'h0000_0105, 2'h0);
        repeat (10) @(posedge aclk);
        rd(8'h20); chk(rv, 32'h4b);
        chk(32'(pin_o), 32'h0);
        rd(8'h10); chk(rv, 32'h8);
        chk(32'(cl), 32'h2);
        wr(8'h24, 32'h0000_0104, 2'h0); rd(8'h20); chk(rv, 32'h4a);
        // second reset with both run bits low
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h10); chk(rv, 32'h0);
        rd(8'h14); chk(rv, 32'h0);
        rd(8'h18); chk(rv, 32'h0);
        // external clock, inverted pin, four-cycle pulse
        wr(8'h18, 32'h0000_0003, 2'h0);
        wr(8'h20, 32'h0000_0174, 2'h0);
        chk(32'(pin_oe), 32'h0);
        wr(8'h24, 32'h0000_0005, 2'h0);
        pin_ticks(2);
        pin_i <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(8'h10); chk(rv, 32'h2);
        pin_i <= 1'b0;
        k = 0;
        repeat (12) begin
            @(posedge aclk);
            if (pin_o === 1'b1) k++;
        end
        chk(32'(k), 32'h4);
        chk(32'(cl), 32'h1);
        // continuous on external ticks: clears on the next tick after a match
        wr(8'h20, 32'h0000_01b4, 2'h0);
        pin_ticks(6);
        rd(8'h10); chk(rv, 32'h1);
        chk(32'(cl), 32'h2);
        // 64-bit mode: one run bit alone counts nothing
        wr(8'h24, 32'h0000_0001, 2'h0);
        wr(8'h20, 32'h0000_0040, 2'h0);
        wr(8'h18, 32'h0000_0009, 2'h0);
        repeat (10) @(posedge aclk);
        rd(8'h10); chk(rv, 32'h1);
        wr(8'h24, 32'h0000_0003, 2'h0);
        repeat (20) @(posedge aclk);
        rd(8'h10); chk(rv, 32'h9);
        rd(8'h14); chk(rv, 32'h0);
        chk(32'(cl), 32'h3);
        // chained: upper matches step the lower counter
        wr(8'h24, 32'h0000_000d, 2'h0);
        wr(8'h1c, 32'h0000_0002, 2'h0);
        wr(8'h18, 32'h0000_000b, 2'h0);
        wr(8'h24, 32'h0000_000f, 2'h0);
        repeat (30) @(posedge aclk);
        rd(8'h10); chk(rv, 32'hb);
        chk(32'(cl), 32'h4);
        chk(32'(ch), 32'h0);
        chk(32'(bad), 32'h0);
        final_report();
    end
endmodule : gp_timer_period_control_tb
